// [hdl/dspcd_decoder.sv]
// Registered decoder for control-format instruction words and shared fields.
// Assumes the fetch unit and status sources run on sys_clk; the flag input
// pin is asynchronous and is synchronised here.
//
// Behaviour
// [RULE1] Stack format yields pc, loop, counter pops
// [RULE2] Flag branch builds 14-bit target, kind, condition
// [RULE3] Flag branch taken when latched input matches
// [RULE4] Flag-out format gives control and predicate
// [RULE5] Flag-out: keep, toggle, clear, set pin
// [RULE6] Recognise no-op, idle and reserved words
// [RULE7] Decode multiplier function codes and formats
// [RULE8] Predicates zero to seven: compares, overflow
// [RULE9] Predicates eight up: carry, sign, mac, loop
// [RULE10] Counter pop bit pops loop counter stack
// [RULE11] Loop pop bit pops loop address stack
// [RULE12] Direction zero reads, one writes memory
// [RULE13] Dual-fetch destination picks X input register
// [RULE14] Data register select maps sixteen registers
// [RULE15] Decode arithmetic unit function codes
// [RULE16] Zero Y operand alters four functions
// [RULE17] Generator select offsets index and modify
//
`timescale 1ns/10ps
`default_nettype none
module dspcd_decoder
(
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Fetched word.
  input  wire logic                  instrValid,
  input  wire logic [23:0]           instrWord,
  // Shared field sources, extracted by the fetch unit per format.
  input  wire logic [4:0]            aluMacFunctionField,
  input  wire logic                  yOperandZero,
  input  wire logic                  xferWay,
  input  wire logic [1:0]            dualFetchDmDest,
  input  wire logic [3:0]            dataRegisterSelect,
  input  wire logic                  addressUnitSelect,
  input  wire logic [1:0]            pointerSlot,
  input  wire logic [1:0]            stepSlot,
  // Status.
  input  wire logic                  aluZero,
  input  wire logic                  aluNeg,
  input  wire logic                  aluOvf,
  input  wire logic                  aluCarry,
  input  wire logic                  xSignNeg,
  input  wire logic                  macOvf,
  input  wire logic                  cntExpired,
  // Pins.
  input  wire logic                  flagInputPin,
  output logic                       flagOutPin,
  // Sequencer controls.
  output dspcd_pkg::dspcd_fmt_e      format,
  output logic                       pcStackPop,
  output logic                       loopStackPop,
  output logic                       counterStackPop,
  output logic [1:0]                 statusStackAction,
  output logic                       branchTaken,
  output logic                       branchKind,
  output logic [13:0]                branchTarget,
  output logic                       idleReq,
  output logic                       reservedOp,
  // Computation controls.
  output dspcd_pkg::dspcd_mac_e      macOp,
  output logic [1:0]                 macFormat,
  output dspcd_pkg::dspcd_alu_e      aluOp,
  output logic                       memWrite,
  output logic                       memRead,
  output logic [3:0]                 dualFetchDstOneHot,
  output logic [15:0]                dataRegOneHot,
  output logic [2:0]                 indexRegNum,
  output logic [2:0]                 modifyRegNum
);

  ////////////////////////////////////////////////////////////////////////////
  // Flag input synchroniser and latch.

  logic flagSync1;   // First stage, read only by the second stage.
  logic flagSync2;   // Second stage, safe to use.
  logic flagLatched; // Level held for the flag branch test.

  // Two flops guard against metastability from the asynchronous pin.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      flagSync1 <= 1'b0;
      flagSync2 <= 1'b0;
      flagLatched <= 1'b0;
    end
    else
    begin
      flagSync1 <= flagInputPin;
      flagSync2 <= flagSync1;
      flagLatched <= flagSync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Format classification.

  logic [7:0]            opc;        // Bits 23..16 of the word.
  dspcd_pkg::dspcd_fmt_e next_format; // Combinational format class.

  assign opc = instrWord[dspcd_pkg::OPC_HI:dspcd_pkg::OPC_LO];

  // Stack and flag-out formats need their must-be-zero bits checked; otherwise they are other.
  always_comb
  begin
    next_format = dspcd_pkg::FMT_OTHER;
    if (instrWord == '0)
      next_format = dspcd_pkg::FMT_NOP; // see [RULE6]
    else if (instrWord == dspcd_pkg::IDLE_WORD)
      next_format = dspcd_pkg::FMT_IDLE; // see [RULE6]
    else if (opc == dspcd_pkg::OPC_RSVD)
      next_format = dspcd_pkg::FMT_RSVD; // see [RULE6]
    else if (opc == dspcd_pkg::OPC_STACK && instrWord[15:5] == '0)
      next_format = dspcd_pkg::FMT_STACK; // see [RULE1]
    else if (opc == dspcd_pkg::OPC_FLAGBR)
      next_format = dspcd_pkg::FMT_FLAGBR; // see [RULE2]
    else if (opc == dspcd_pkg::OPC_FLAGOUT && instrWord[15:6] == '0)
      next_format = dspcd_pkg::FMT_FLAGOUT; // see [RULE4]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition evaluation for the flag-out format.

  logic condTrue; // Predicate result for bits 3..0.

  dspcd_predicate_sel_eval u_predicate_sel
  (
    .predicateSel (instrWord[3:0]),
    .aluZero      (aluZero),
    .aluNeg       (aluNeg),
    .aluOvf       (aluOvf),
    .aluCarry     (aluCarry),
    .xSignNeg     (xSignNeg),
    .macOvf       (macOvf),
    .cntExpired   (cntExpired),
    .condTrue     (condTrue)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer controls; pulses last one cycle after the valid word.

  // Registered one cycle after instrValid; a non-matching word gives zeros except branchTarget and branchKind, which hold.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      format <= dspcd_pkg::FMT_NOP;
      pcStackPop <= 1'b0;
      loopStackPop <= 1'b0;
      counterStackPop <= 1'b0;
      statusStackAction <= 2'h0;
      branchTaken <= 1'b0;
      branchKind <= 1'b0;
      branchTarget <= '0;
      idleReq <= 1'b0;
      reservedOp <= 1'b0;
    end
    else
    begin
      format <= instrValid ? next_format : dspcd_pkg::FMT_NOP;
      pcStackPop <= 1'b0;
      loopStackPop <= 1'b0;
      counterStackPop <= 1'b0;
      statusStackAction <= 2'h0;
      branchTaken <= 1'b0;
      idleReq <= instrValid && next_format == dspcd_pkg::FMT_IDLE;
      reservedOp <= instrValid && next_format == dspcd_pkg::FMT_RSVD;
      if (instrValid && next_format == dspcd_pkg::FMT_STACK)
      begin
        pcStackPop <= instrWord[dspcd_pkg::PC_POP_BIT]; // see [RULE1]
        loopStackPop <= instrWord[dspcd_pkg::LOOP_POP_BIT]; // see [RULE11]
        counterStackPop <= instrWord[dspcd_pkg::CNT_POP_BIT]; // see [RULE10]
        statusStackAction <= instrWord[1:0];
      end
      if (instrValid && next_format == dspcd_pkg::FMT_FLAGBR)
      begin
        // High bits from 3..2 sit above the twelve low bits.
        branchTarget <= {instrWord[dspcd_pkg::TGT_HI_HI:dspcd_pkg::TGT_HI_LO],
          instrWord[dspcd_pkg::TGT_LO_HI:dspcd_pkg::TGT_LO_LO]}; // see [RULE2]
        branchKind <= instrWord[dspcd_pkg::KIND_BIT];
        branchTaken <= (flagLatched ==
          instrWord[dspcd_pkg::FIC_BIT]); // see [RULE3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag output pin.

  // Pin changes only when the flag-out format's predicate holds.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      flagOutPin <= dspcd_pkg::FLAG_OUT_RST;
    else if (instrValid && next_format == dspcd_pkg::FMT_FLAGOUT && condTrue)
    begin
      case (instrWord[5:4]) // see [RULE5]
        dspcd_pkg::FO_TOGGLE: flagOutPin <= ~flagOutPin;
        dspcd_pkg::FO_CLEAR:  flagOutPin <= 1'b0;
        dspcd_pkg::FO_SET:    flagOutPin <= 1'b1;
        default:              flagOutPin <= flagOutPin;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function field decode.

  dspcd_pkg::dspcd_mac_e next_macOp;  // Multiplier class.
  dspcd_pkg::dspcd_alu_e next_aluOp;  // Arithmetic unit operation.

  // Top bit picks the unit; low two bits give the operand format.
  always_comb
  begin
    next_macOp = dspcd_pkg::MAC_NONE;
    next_aluOp = dspcd_pkg::ALU_NONE;
    if (!aluMacFunctionField[4])
    begin
      case (aluMacFunctionField[3:2]) // see [RULE7]
        2'h0:
          case (aluMacFunctionField[1:0])
            2'h0: next_macOp = dspcd_pkg::MAC_NONE;
            2'h2: next_macOp = dspcd_pkg::MAC_RND_ADD;
            2'h3: next_macOp = dspcd_pkg::MAC_RND_SUB;
            default: next_macOp = dspcd_pkg::MAC_UNDEF;
          endcase
        2'h1: next_macOp = (aluMacFunctionField[1:0] == 2'h0 && yOperandZero)
          ? dspcd_pkg::MAC_CLEAR : dspcd_pkg::MAC_MUL; // see [RULE16]
        2'h2: next_macOp = dspcd_pkg::MAC_ADD;
        default: next_macOp = dspcd_pkg::MAC_SUB;
      endcase
    end
    else
    begin
      case (aluMacFunctionField[3:0]) // see [RULE15]
        4'h0: next_aluOp = yOperandZero ? dspcd_pkg::ALU_CLEAR
          : dspcd_pkg::ALU_PASS_Y; // see [RULE16]
        4'h1: next_aluOp = dspcd_pkg::ALU_Y_INC;
        4'h2: next_aluOp = dspcd_pkg::ALU_XY_C;
        4'h3: next_aluOp = yOperandZero ? dspcd_pkg::ALU_PASS_X
          : dspcd_pkg::ALU_XY; // see [RULE16]
        4'h4: next_aluOp = dspcd_pkg::ALU_NOT_Y;
        4'h5: next_aluOp = dspcd_pkg::ALU_NEG_Y;
        4'h6: next_aluOp = dspcd_pkg::ALU_XMY_C;
        4'h7: next_aluOp = dspcd_pkg::ALU_XMY;
        4'h8: next_aluOp = dspcd_pkg::ALU_Y_DEC;
        4'h9: next_aluOp = yOperandZero ? dspcd_pkg::ALU_NEG_X
          : dspcd_pkg::ALU_YMX; // see [RULE16]
        4'hA: next_aluOp = dspcd_pkg::ALU_YMX_C;
        4'hB: next_aluOp = dspcd_pkg::ALU_NOT_X;
        4'hC: next_aluOp = dspcd_pkg::ALU_AND;
        4'hD: next_aluOp = dspcd_pkg::ALU_OR;
        4'hE: next_aluOp = dspcd_pkg::ALU_XOR;
        default: next_aluOp = dspcd_pkg::ALU_ABS_X;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared field registers.

  // Held from the last valid word so the units see stable selects.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      macOp <= dspcd_pkg::MAC_NONE;
      macFormat <= 2'h0;
      aluOp <= dspcd_pkg::ALU_NONE;
      memWrite <= 1'b0;
      memRead <= 1'b0;
      dualFetchDstOneHot <= 4'h0;
      dataRegOneHot <= 16'h0000;
      indexRegNum <= 3'h0;
      modifyRegNum <= 3'h0;
    end
    else if (instrValid)
    begin
      macOp <= next_macOp;
      macFormat <= aluMacFunctionField[1:0]; // SS, SU, US, UU order.
      aluOp <= next_aluOp;
      memWrite <= xferWay; // see [RULE12]
      memRead <= ~xferWay; // see [RULE12]
      // One-hot order: alu_x_in0, alu_x_in1, mac_x_in0, mac_x_in1.
      dualFetchDstOneHot <= 4'h1 << dualFetchDmDest; // see [RULE13]
      // Bit n selects register n of the sixteen data registers.
      dataRegOneHot <= 16'h0001 << dataRegisterSelect; // see [RULE14]
      indexRegNum <= {addressUnitSelect, pointerSlot}; // see [RULE17]
      modifyRegNum <= {addressUnitSelect, stepSlot}; // see [RULE17]
    end
  end

endmodule
`default_nettype wire

// [hdl/dspcd_pkg.sv]
// Package for the control-format instruction decoder.
// Assumes a 24-bit instruction word and a single core clock.
package dspcd_pkg;
  // Word geometry.
  localparam int INSTR_W  = 24;
  localparam int OPC_HI   = 23;
  localparam int OPC_LO   = 16;
  // Opcode values in bits 23..16.
  localparam logic [7:0] OPC_STACK  = 8'h04;
  localparam logic [7:0] OPC_FLAGBR = 8'h03;
  localparam logic [7:0] OPC_FLAGOUT = 8'h02;
  localparam logic [7:0] OPC_RSVD   = 8'h01;
  localparam logic [7:0] OPC_NOP    = 8'h00;
  // Idle word: bits 23..15 equal 000000101 and the rest zero.
  localparam logic [23:0] IDLE_WORD = 24'h028000;
  // Stack control field positions.
  localparam int PC_POP_BIT   = 4;
  localparam int LOOP_POP_BIT = 3;
  localparam int CNT_POP_BIT  = 2;
  // Flag branch field positions.
  localparam int TGT_LO_HI = 15;
  localparam int TGT_LO_LO = 4;
  localparam int TGT_HI_HI = 3;
  localparam int TGT_HI_LO = 2;
  localparam int FIC_BIT   = 1;
  localparam int KIND_BIT  = 0;
  localparam int TARGET_W  = 14;
  // Flag output control codes.
  localparam logic [1:0] FO_KEEP   = 2'h0;
  localparam logic [1:0] FO_TOGGLE = 2'h1;
  localparam logic [1:0] FO_CLEAR  = 2'h2;
  localparam logic [1:0] FO_SET    = 2'h3;
  // Status stack action codes.
  localparam logic [1:0] SS_PUSH = 2'h2;
  localparam logic [1:0] SS_POP  = 2'h3;
  // Reset level of the output flag.
  localparam logic FLAG_OUT_RST = 1'b0;
  // Format classes of a decoded word.
  typedef enum logic [2:0] {
    FMT_OTHER, FMT_STACK, FMT_FLAGBR, FMT_FLAGOUT,
    FMT_RSVD, FMT_NOP, FMT_IDLE
  } dspcd_fmt_e;
  // Multiplier operation classes.
  typedef enum logic [2:0] {
    MAC_NONE, MAC_RND_ADD, MAC_RND_SUB, MAC_MUL, MAC_ADD, MAC_SUB,
    MAC_CLEAR, MAC_UNDEF
  } dspcd_mac_e;
  // Arithmetic unit operations.
  typedef enum logic [4:0] {
    ALU_NONE, ALU_PASS_Y, ALU_Y_INC, ALU_XY_C, ALU_XY, ALU_NOT_Y,
    ALU_NEG_Y, ALU_XMY_C, ALU_XMY, ALU_Y_DEC, ALU_YMX, ALU_YMX_C,
    ALU_NOT_X, ALU_AND, ALU_OR, ALU_XOR, ALU_ABS_X, ALU_CLEAR,
    ALU_PASS_X, ALU_NEG_X
  } dspcd_alu_e;
endpackage

// [hdl/dspcd_predicate_sel_eval.sv]
// Predicate evaluator for the 4-bit condition select.
// Assumes status bits come from the same clock domain, already registered.
`timescale 1ns/10ps
`default_nettype none
module dspcd_predicate_sel_eval
(
  // Condition select.
  input  wire logic [3:0] predicateSel,
  // Status inputs.
  input  wire logic       aluZero,
  input  wire logic       aluNeg,
  input  wire logic       aluOvf,
  input  wire logic       aluCarry,
  input  wire logic       xSignNeg,
  input  wire logic       macOvf,
  input  wire logic       cntExpired,
  // Result.
  output logic            condTrue
);
  // Pure decode; the caller registers the result.
  always_comb
  begin
    case (predicateSel)
      4'h0: condTrue = aluZero; // see [RULE8]
      4'h1: condTrue = ~aluZero;
      4'h2: condTrue = ~(aluNeg ^ aluOvf) & ~aluZero;
      4'h3: condTrue = (aluNeg ^ aluOvf) | aluZero;
      4'h4: condTrue = aluNeg ^ aluOvf;
      4'h5: condTrue = ~(aluNeg ^ aluOvf);
      4'h6: condTrue = aluOvf;
      4'h7: condTrue = ~aluOvf;
      4'h8: condTrue = aluCarry; // see [RULE9]
      4'h9: condTrue = ~aluCarry;
      4'hA: condTrue = xSignNeg;
      4'hB: condTrue = ~xSignNeg;
      4'hC: condTrue = macOvf;
      4'hD: condTrue = ~macOvf;
      4'hE: condTrue = ~cntExpired;
      default: condTrue = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// [test/dspcd_decoder_bench.sv]
// Self-checking bench for the control-format decoder.
// Assumes the sequencer model and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module dspcd_decoder_bench;
  logic        sys_clk = 1'b0;   // 125 MHz core clock.
  logic        rst_n = 1'b0;     // Synchronous reset, active low.
  logic        instrValid;       // From the sequencer model.
  logic [23:0] instrWord;        // From the sequencer model.
  logic [4:0]  alu_mac_function_field = 5'h00;      // Function field.
  logic        yZero = 1'b0;     // Y operand is constant zero.
  logic        xfer = 1'b0;      // Memory direction.
  logic [3:0]  fld = 4'h0;       // Source of all register select fields.
  logic [6:0]  st = 7'h00;       // Status bits.
  logic        pin = 1'b0;       // Flag input pin.
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // Row: expected flag level, format, pops, then the word sent.
  logic [32:0] rows [8] = '{{9'h030, 24'h040010}, {9'h02B, 24'h04000B},
    {9'h0A0, 24'h000000}, {9'h000, 24'h040020}, {9'h160, 24'h02001F},
    {9'h160, 24'h02000F}, {9'h1C0, 24'h028000}, {9'h180, 24'h01ABCD}};
  // Predicate truth with every status bit low, then every bit high.
  logic [15:0] tru [2] = '{16'hEAA6, 16'h9569};
  wire logic flagOutPin, pcPop, lpPop, cntPop, taken, kind, memWr, memRd;
  wire logic [1:0]  ssAct;
  wire logic [13:0] target;
  wire dspcd_pkg::dspcd_fmt_e format;
  wire dspcd_pkg::dspcd_mac_e macOp;
  wire logic [1:0]  macFormat;
  wire dspcd_pkg::dspcd_alu_e aluOp;
  ////////////////////////////////////////////////////////////////////////
  always #4 sys_clk = ~sys_clk;
  dspcd_seq_model dspcd_seq_model_i (.sys_clk(sys_clk),
    .instrValid(instrValid), .instrWord(instrWord));
  dspcd_decoder dspcd_decoder_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .instrValid(instrValid), .instrWord(instrWord),
    .aluMacFunctionField(alu_mac_function_field), .yOperandZero(yZero), .xferWay(xfer),
    .dualFetchDmDest(fld[1:0]), .dataRegisterSelect(fld),
    .addressUnitSelect(fld[3]), .pointerSlot(fld[1:0]),
    .stepSlot(fld[2:1]), .aluZero(st[0]), .aluNeg(st[1]), .aluOvf(st[2]),
    .aluCarry(st[3]), .xSignNeg(st[4]), .macOvf(st[5]),
    .cntExpired(st[6]), .flagInputPin(pin), .flagOutPin(flagOutPin),
    .format(format), .pcStackPop(pcPop), .loopStackPop(lpPop),
    .counterStackPop(cntPop), .statusStackAction(ssAct),
    .branchTaken(taken), .branchKind(kind), .branchTarget(target),
    .idleReq(), .reservedOp(), .macOp(macOp), .macFormat(macFormat),
    .aluOp(aluOp), .memWrite(memWr), .memRead(memRd), .dualFetchDstOneHot(),
    .dataRegOneHot(), .indexRegNum(), .modifyRegNum());
  ////////////////////////////////////////////////////////////////////////
  // Counts one comparison and reports it at once if it failed.
  task automatic chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("BAD %0t mismatch at check %0d", $time, num_checks);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Sends a word with its fields and waits until the answer has settled.
  task automatic send(input logic [23:0] w, input logic [3:0] f);
    @(posedge sys_clk);
    fld  <= f;
    xfer <= f[0];
    dspcd_seq_model_i.put(w);
    #1;
  endtask
  // Sends a no-op carrying a function code and the zero-Y flag.
  task automatic op(input logic [5:0] a);
    @(posedge sys_clk);
    yZero <= a[5];
    alu_mac_function_field   <= a[4:0];
    send(24'h000000, 4'h0);
  endtask
  // A hang is cut short well beyond the few hundred cycles needed.
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk(format === dspcd_pkg::FMT_NOP && flagOutPin === 1'b0);
    // Table of plain words; the checker also judges the fields each time.
    for (int i = 0; i < 8; i++)
    begin
      send(rows[i][23:0], 4'(i));
      chk(format === dspcd_pkg::dspcd_fmt_e'(rows[i][31:29]));
      chk({pcPop, lpPop, cntPop, ssAct} === rows[i][28:24]);
      chk(flagOutPin === rows[i][32]);
      chk(memWr === xfer && memRd === !xfer);
    end
    // Each predicate qualifies a set after a clear, in two status cases.
    for (int k = 0; k < 32; k++)
    begin
      @(posedge sys_clk);
      st <= {7{k[4]}};
      send(24'h02002F, 4'(k));
      send(24'h020030 | 24'(k[3:0]), 4'(k));
      chk(flagOutPin === tru[k[4]][k[3:0]]);
    end
    // Branch on the latched pin, both polarities of the condition bit.
    @(posedge sys_clk);
    pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    send(24'h03ABCF, 4'h0);
    chk(taken === 1'b1 && target === 14'h3ABC && kind === 1'b1);
    send(24'h03ABCD, 4'h0);
    chk(taken === 1'b0);
    @(posedge sys_clk);
    pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    send(24'h03ABCD, 4'h0);
    chk(taken === 1'b1);
    // Function codes, with and without the zero Y operand.
    op(6'h06);
    chk(macOp === dspcd_pkg::MAC_MUL && macFormat === 2'h2);
    op(6'h03);
    chk(macOp === dspcd_pkg::MAC_RND_SUB);
    op(6'h24);
    chk(macOp === dspcd_pkg::MAC_CLEAR);
    op(6'h13);
    chk(aluOp === dspcd_pkg::ALU_XY);
    op(6'h33);
    chk(aluOp === dspcd_pkg::ALU_PASS_X);
    op(6'h39);
    chk(aluOp === dspcd_pkg::ALU_NEG_X);
    // A reset in mid-run drops the raised flag and the held controls.
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk(flagOutPin === 1'b0 && aluOp === dspcd_pkg::ALU_NONE);
    summarize();
  end
endmodule
`default_nettype wire

// [test/dspcd_decoder_props.sv]
// Concurrent checks on the ports of the control-format decoder.
// Assumes one clock, synchronous active-low reset, one-cycle answer.
`timescale 1ns/10ps
`default_nettype none
module dspcd_decoder_props
(
  // Clock and reset.
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  // Word, fields and pin seen by the decoder.
  input wire logic                  instrValid,
  input wire logic [23:0]           instrWord,
  input wire logic [1:0]            dualFetchDmDest,
  input wire logic [3:0]            dataRegisterSelect,
  input wire logic                  addressUnitSelect,
  input wire logic [1:0]            pointerSlot,
  input wire logic [1:0]            stepSlot,
  input wire logic                  flagInputPin,
  // Decoded outputs under judgement.
  input wire logic                  flagOutPin,
  input wire dspcd_pkg::dspcd_fmt_e format,
  input wire logic                  pcStackPop,
  input wire logic                  loopStackPop,
  input wire logic                  counterStackPop,
  input wire logic [1:0]            statusStackAction,
  input wire logic                  branchTaken,
  input wire logic                  branchKind,
  input wire logic [13:0]           branchTarget,
  input wire logic                  idleReq,
  input wire logic                  reservedOp,
  input wire logic [3:0]            dualFetchDstOneHot,
  input wire logic [15:0]           dataRegOneHot,
  input wire logic [2:0]            indexRegNum,
  input wire logic [2:0]            modifyRegNum
);
  // All checks share the core clock and are quiet during reset.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Word classes, named so each property reads as cause then effect.
  sequence stackWord;
    instrValid && instrWord[23:5] == {dspcd_pkg::OPC_STACK, 11'h000};
  endsequence
  sequence branchWord;
    instrValid && instrWord[23:16] == dspcd_pkg::OPC_FLAGBR;
  endsequence
  // The pin must have been still long enough to pass the synchroniser.
  sequence pinSettled;
    $stable(flagInputPin)[*6];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_STACK_POPS: assert property (
    stackWord |=> format == dspcd_pkg::FMT_STACK
    && {pcStackPop, loopStackPop, counterStackPop, statusStackAction}
    == $past(instrWord[4:0])) else $error("stack pops wrong");
  AST_STACK_REFUSE: assert property (instrValid
    && instrWord[23:16] == dspcd_pkg::OPC_STACK && instrWord[15:5] != 11'h000
    |=> format == dspcd_pkg::FMT_OTHER && !pcStackPop)
    else $error("bad stack word accepted");
  AST_BRANCH_FIELDS: assert property (branchWord |=>
    branchTarget == {$past(instrWord[3:2]), $past(instrWord[15:4])}
    && branchKind == $past(instrWord[0])) else $error("branch fields wrong");
  AST_BRANCH_TAKEN: assert property (
    pinSettled ##0 branchWord |=>
    branchTaken == $past(instrWord[1] == flagInputPin))
    else $error("branch decision wrong");
  AST_FLAG_OUT: assert property (instrValid
    && instrWord[23:6] == {dspcd_pkg::OPC_FLAGOUT, 10'h000}
    && instrWord[3:0] == 4'hF |=> flagOutPin == ($past(instrWord[5])
    ? $past(instrWord[4]) : $past(flagOutPin) ^ $past(instrWord[4])))
    else $error("flag out level wrong");
  AST_IDLE: assert property (
    instrValid && instrWord == dspcd_pkg::IDLE_WORD
    |=> idleReq && format == dspcd_pkg::FMT_IDLE) else $error("idle missed");
  AST_RESERVED: assert property (instrValid
    && instrWord[23:16] == dspcd_pkg::OPC_RSVD |=> reservedOp && !idleReq)
    else $error("reserved missed");
  AST_PULSE_END: assert property (
    !instrValid |=> format == dspcd_pkg::FMT_NOP
    && !pcStackPop && !branchTaken && !idleReq && !reservedOp)
    else $error("pulse held over");
  AST_DATA_REG: assert property (instrValid |=>
    $onehot(dataRegOneHot) && dataRegOneHot[$past(dataRegisterSelect)])
    else $error("data register select wrong");
  AST_DUAL_DEST: assert property (instrValid |=>
    $onehot(dualFetchDstOneHot)
    && dualFetchDstOneHot[$past(dualFetchDmDest)])
    else $error("dual fetch destination wrong");
  AST_ADDR_GEN: assert property (instrValid |=>
    indexRegNum == {$past(addressUnitSelect), $past(pointerSlot)}
    && modifyRegNum == {$past(addressUnitSelect), $past(stepSlot)})
    else $error("address register number wrong");
endmodule
bind dspcd_decoder dspcd_decoder_props dspcd_decoder_props_i
(
  .sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid),
  .instrWord(instrWord), .dualFetchDmDest(dualFetchDmDest),
  .dataRegisterSelect(dataRegisterSelect),
  .addressUnitSelect(addressUnitSelect), .pointerSlot(pointerSlot),
  .stepSlot(stepSlot), .flagInputPin(flagInputPin),
  .flagOutPin(flagOutPin), .format(format), .pcStackPop(pcStackPop),
  .loopStackPop(loopStackPop), .counterStackPop(counterStackPop),
  .statusStackAction(statusStackAction), .branchTaken(branchTaken),
  .branchKind(branchKind), .branchTarget(branchTarget),
  .idleReq(idleReq), .reservedOp(reservedOp),
  .dualFetchDstOneHot(dualFetchDstOneHot), .dataRegOneHot(dataRegOneHot),
  .indexRegNum(indexRegNum), .modifyRegNum(modifyRegNum)
);
`default_nettype wire

// [test/dspcd_seq_model.sv]
// Behavioural program sequencer that hands fetched words to the decoder.
// Assumes the decoder takes a word at the rising edge with valid high.
`timescale 1ns/10ps
`default_nettype none
module dspcd_seq_model
(
  // Core clock.
  input  wire logic        sys_clk,
  // Fetched word towards the decoder.
  output var  logic        instrValid,
  output var  logic [23:0] instrWord
);
  // Nothing is offered until the bench asks.
  initial
  begin
    instrValid = 1'b0;
    instrWord  = 24'h000000;
  end
  // Offers one word for one cycle; afterwards the bus shows the inverse so
  // that a decoder reading a stale word cannot pass by luck.
  task automatic put(input logic [23:0] w);
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instrWord  <= w;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    instrWord  <= ~w;
  endtask
endmodule
`default_nettype wire
